// ==== pkg/vref_dac_pkg.sv ====
`default_nettype none
package vref_dac_pkg;

  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] FIXED_REFERENCE_CONTROL_OFFSET = 8'h00;
  localparam logic [7:0] DAC_CONTROL_MAIN_OFFSET        = 8'h04;
  localparam logic [7:0] DAC_LEVEL_SELECT_OFFSET        = 8'h08;
  localparam logic [7:0] SLEEP_CONTROL_OFFSET           = 8'h0C;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int REF_ENABLE_BIT               = 7;
  localparam int REF_READY_FLAG_BIT           = 6;
  localparam int REF_BUFFER_ENABLE_BIT        = 5;
  localparam int REF_BUFFER_SOURCE_SELECT_BIT = 4;
  localparam int CONVERTER_ENABLE_BIT         = 7;
  localparam int CONVERTER_RANGE_SELECT_BIT   = 6;
  localparam int CONVERTER_PIN_OE_BIT         = 5;
  localparam int CONVERTER_SOURCE_SELECT_BIT  = 2;
  localparam int LEVEL_CODE_WIDTH             = 5;

  // implemented-bit masks; all other bits read as zero
  localparam logic [7:0] FIXED_REFERENCE_CONTROL_MASK = 8'hF0;
  localparam logic [7:0] DAC_CONTROL_MAIN_MASK        = 8'hE4;
  localparam logic [7:0] DAC_LEVEL_SELECT_MASK        = 8'h1F;
  localparam logic [7:0] FIXED_REFERENCE_WRITE_MASK   = 8'hB0;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_RESET_VALUE = 8'h00;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLOCK_PERIOD_PS     = 5000;
  localparam int SETTLE_TIME_US      = 25;
  localparam int SETTLE_CYCLES       = (SETTLE_TIME_US * 1000000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;
  localparam int SETTLE_COUNT_WIDTH  = 16;

  // output buffer source encoding
  localparam logic BUFFER_SOURCE_BANDGAP = 1'b0;
  localparam logic BUFFER_SOURCE_DAC     = 1'b1;

endpackage
`default_nettype wire

// ==== verilog/ref_settle_timer.sv ====
`timescale 1ns/100ps
`default_nettype none
module ref_settle_timer #(
  parameter logic [15:0] SETTLE_COUNT = 16'h1388           // cycles until the reference is ready
) (
  input  wire logic pclk,                                    // system clock
  input  wire logic presetn,                                 // async reset, active low
  input  wire logic enable,                                  // effective reference enable
  output var  logic ready                                    // reference has settled
);

  typedef enum logic [1:0] {
    TIMER_OFF      = 2'b00,
    TIMER_SETTLING = 2'b01,
    TIMER_READY    = 2'b11
  } timer_state_type;

  typedef struct packed {
    timer_state_type state;
    logic [15:0]     count;
    logic            ready;
  } timer_type;

  timer_type cur;
  timer_type next_cur;

  // --------------------------------------------------------------
  // settle sequencing
  // --------------------------------------------------------------
  // disable drops ready at once; a re-enable restarts the count
  always_comb begin
    next_cur = cur;
    unique case (cur.state)
      TIMER_OFF: begin
        next_cur.count = 16'h0000;
        if (enable) begin
          next_cur.state = TIMER_SETTLING;
        end
      end
      TIMER_SETTLING: begin
        next_cur.count = cur.count + 16'h0001;
        if (cur.count + 16'h0001 >= SETTLE_COUNT) begin
          next_cur.state = TIMER_READY;
        end
      end
      TIMER_READY: begin
        next_cur.count = cur.count;
      end
      default: begin
        next_cur.state = TIMER_OFF;
      end
    endcase
    if (!enable) begin
      next_cur.state = TIMER_OFF;
      next_cur.count = 16'h0000;
    end
    next_cur.ready = (next_cur.state == TIMER_READY);
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur <= '{state: TIMER_OFF, count: 16'h0000, ready: 1'b0};
    end else begin
      cur <= next_cur;
    end
  end

  assign ready = cur.ready;

  AST_READY_DROPS: assert property (@(posedge pclk) disable iff (!presetn)
    !enable |=> !ready) else $error("ready stayed up after disable");

  AST_NOT_EARLY: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(enable) && !ready |=> !ready [*3]) else $error("ready rose too soon");

endmodule // ref_settle_timer
`default_nettype wire

// ==== verilog/voltage_ref_dac_control.sv ====
`timescale 1ns/100ps
`default_nettype none
module voltage_ref_dac_control #(
  parameter bit          HIGH_VOLTAGE_VARIANT = 1'b0,        // reference is always on when set
  parameter logic [15:0] SETTLE_COUNT         = 16'(vref_dac_pkg::SETTLE_CYCLES) // settle cycles
) (
  input  wire logic        pclk,                             // apb clock, 200 MHz
  input  wire logic        presetn,                          // async reset, active low
  input  wire logic        psel,                             // apb select
  input  wire logic        penable,                          // apb access phase
  input  wire logic        pwrite,                           // apb write
  input  wire logic [7:0]  paddr,                            // apb byte address
  input  wire logic [31:0] pwdata,                           // apb write data
  input  wire logic [3:0]  pstrb,                            // apb byte strobes
  output var  logic        pready,                           // apb ready
  output var  logic [31:0] prdata,                           // apb read data
  output var  logic        pslverr,                          // apb error, unmapped address
  input  wire logic        ref_pin_in,                       // digital level on shared pin
  output var  logic        ref_pin_digital_in,               // pin level seen by port logic
  output var  logic        pin_digital_override,             // pin taken by analog output
  output var  logic        ref_enable_out,                   // fixed reference power
  output var  logic        ref_ready_flag,                   // fixed reference settled
  output var  logic        ref_buffer_enable,                // buffered pin driver on
  output var  logic        ref_buffer_source_select,         // buffer input: 0 bandgap, 1 converter
  output var  logic        converter_enable,                 // converter ladder on
  output var  logic        converter_range_select,           // 1 full range, 0 limited
  output var  logic        converter_source_select,          // 0 supply, 1 external reference
  output var  logic [4:0]  converter_level_code,             // ladder tap
  output var  logic        unbuffered_converter_pin,         // ladder routed straight to pin
  output var  logic        buffered_reference_pin,           // pin driven through buffer
  output var  logic        sleep_active                      // device asleep (held by software)
);

  // --------------------------------------------------------------
  // state
  // --------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  fixed_reference_control;                    // bit 6 unused, ready comes live
    logic [7:0]  dac_control_main;
    logic [7:0]  dac_level_select;
    logic        sleep;
    logic        pin_meta;
    logic        pin_sync;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic        ref_enable_out;
    logic        ref_ready_flag;
    logic        ref_buffer_enable;
    logic        ref_buffer_source_select;
    logic        converter_enable;
    logic        converter_range_select;
    logic        converter_source_select;
    logic [4:0]  converter_level_code;
    logic        unbuffered_converter_pin;
    logic        buffered_reference_pin;
    logic        pin_override;
    logic        pin_digital_in;
  } ctrl_type;

  ctrl_type cur;
  ctrl_type next_cur;
  logic     settle_ready;
  logic     eff_enable;

  // merge one byte lane of write data under the implemented-bit mask
  function automatic logic [7:0] merge_byte(input logic [7:0] old_value, input logic [7:0] wdata,
                                           input logic lane, input logic [7:0] mask);
    merge_byte = lane ? ((old_value & ~mask) | (wdata & mask)) : old_value;
  endfunction

  // --------------------------------------------------------------
  // reference settle timer
  // --------------------------------------------------------------
  // the enable that the analog sees: the variant overrides software
  assign eff_enable = HIGH_VOLTAGE_VARIANT | cur.fixed_reference_control[vref_dac_pkg::REF_ENABLE_BIT];

  ref_settle_timer #(
    .SETTLE_COUNT (SETTLE_COUNT)
  ) u_settle (
    .pclk    (pclk),
    .presetn (presetn),
    .enable  (eff_enable),
    .ready   (settle_ready)
  );

  // --------------------------------------------------------------
  // next state
  // --------------------------------------------------------------
  always_comb begin
    logic       access;
    logic       mapped;
    logic [7:0] rd_byte;
    logic       buf_en;
    logic       buf_ss;
    logic       conv_oe;
    access  = 1'b0;
    mapped  = 1'b0;
    rd_byte = 8'h00;
    buf_en  = 1'b0;
    buf_ss  = 1'b0;
    conv_oe = 1'b0;
    next_cur = cur;

    // apb: access phase with one wait state, pready pulses with the answer
    access = psel && penable && !cur.pready;
    next_cur.pready  = access;
    next_cur.pslverr = 1'b0;
    mapped = (paddr == vref_dac_pkg::FIXED_REFERENCE_CONTROL_OFFSET) ||
             (paddr == vref_dac_pkg::DAC_CONTROL_MAIN_OFFSET) ||
             (paddr == vref_dac_pkg::DAC_LEVEL_SELECT_OFFSET) ||
             (paddr == vref_dac_pkg::SLEEP_CONTROL_OFFSET);
    if (access) begin
      next_cur.pslverr = !mapped;
    end

    // register writes; ready bit is never writable
    if (access && pwrite) begin
      unique case (paddr)
        vref_dac_pkg::FIXED_REFERENCE_CONTROL_OFFSET: begin
          next_cur.fixed_reference_control = merge_byte(cur.fixed_reference_control, pwdata[7:0], pstrb[0],
                                                        vref_dac_pkg::FIXED_REFERENCE_WRITE_MASK);
        end
        vref_dac_pkg::DAC_CONTROL_MAIN_OFFSET: begin
          next_cur.dac_control_main = merge_byte(cur.dac_control_main, pwdata[7:0], pstrb[0],
                                                 vref_dac_pkg::DAC_CONTROL_MAIN_MASK);
        end
        vref_dac_pkg::DAC_LEVEL_SELECT_OFFSET: begin
          next_cur.dac_level_select = merge_byte(cur.dac_level_select, pwdata[7:0], pstrb[0],
                                                 vref_dac_pkg::DAC_LEVEL_SELECT_MASK);
        end
        vref_dac_pkg::SLEEP_CONTROL_OFFSET: begin
          // sleep entry and wake touch no control register
          if (pstrb[0]) begin
            next_cur.sleep = pwdata[0];
          end
        end
        default: begin
        end
      endcase
    end

    // register reads; unimplemented bits come back zero
    unique case (paddr)
      vref_dac_pkg::FIXED_REFERENCE_CONTROL_OFFSET: begin
        rd_byte = cur.fixed_reference_control & vref_dac_pkg::FIXED_REFERENCE_CONTROL_MASK;
        rd_byte[vref_dac_pkg::REF_READY_FLAG_BIT] = settle_ready;
      end
      vref_dac_pkg::DAC_CONTROL_MAIN_OFFSET: begin
        rd_byte = cur.dac_control_main & vref_dac_pkg::DAC_CONTROL_MAIN_MASK;
      end
      vref_dac_pkg::DAC_LEVEL_SELECT_OFFSET: begin
        rd_byte = cur.dac_level_select & vref_dac_pkg::DAC_LEVEL_SELECT_MASK;
      end
      vref_dac_pkg::SLEEP_CONTROL_OFFSET: begin
        rd_byte = {7'h00, cur.sleep};
      end
      default: begin
        rd_byte = 8'h00;
      end
    endcase
    if (access && !pwrite) begin
      next_cur.prdata = {24'h000000, rd_byte};
    end else begin
      next_cur.prdata = 32'h00000000;
    end

    // analog controls, registered on the same edge as the write
    buf_en  = next_cur.fixed_reference_control[vref_dac_pkg::REF_BUFFER_ENABLE_BIT];
    buf_ss  = next_cur.fixed_reference_control[vref_dac_pkg::REF_BUFFER_SOURCE_SELECT_BIT];
    conv_oe = next_cur.dac_control_main[vref_dac_pkg::CONVERTER_PIN_OE_BIT];
    next_cur.ref_enable_out           = HIGH_VOLTAGE_VARIANT |
                                        next_cur.fixed_reference_control[vref_dac_pkg::REF_ENABLE_BIT];
    next_cur.ref_ready_flag           = settle_ready;
    next_cur.ref_buffer_enable        = buf_en;
    next_cur.ref_buffer_source_select = buf_ss;
    next_cur.converter_enable         = next_cur.dac_control_main[vref_dac_pkg::CONVERTER_ENABLE_BIT];
    next_cur.converter_range_select   = next_cur.dac_control_main[vref_dac_pkg::CONVERTER_RANGE_SELECT_BIT];
    next_cur.converter_source_select  = next_cur.dac_control_main[vref_dac_pkg::CONVERTER_SOURCE_SELECT_BIT];
    next_cur.converter_level_code     = next_cur.dac_level_select[vref_dac_pkg::LEVEL_CODE_WIDTH-1:0];

    // shared pin routing: buffer wins over the bare ladder
    next_cur.unbuffered_converter_pin = conv_oe && !buf_ss && !buf_en;
    next_cur.buffered_reference_pin   = buf_en;
    next_cur.pin_override = next_cur.unbuffered_converter_pin || next_cur.buffered_reference_pin;

    // pin input is synchronised, then masked to zero under override
    next_cur.pin_meta       = ref_pin_in;
    next_cur.pin_sync       = cur.pin_meta;
    next_cur.pin_digital_in = cur.pin_sync && !next_cur.pin_override;
  end

  // --------------------------------------------------------------
  // registers
  // --------------------------------------------------------------
  // every reset source clears all three control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur <= '0;
      cur.dac_control_main <= vref_dac_pkg::REG_RESET_VALUE;
      cur.dac_level_select <= vref_dac_pkg::REG_RESET_VALUE;
      cur.fixed_reference_control <= vref_dac_pkg::REG_RESET_VALUE;
      cur.ref_enable_out <= HIGH_VOLTAGE_VARIANT;            // variant never sees it off
    end else begin
      cur <= next_cur;
    end
  end

  // --------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------
  assign pready                   = cur.pready;
  assign prdata                   = cur.prdata;
  assign pslverr                  = cur.pslverr;
  assign ref_pin_digital_in       = cur.pin_digital_in;
  assign pin_digital_override     = cur.pin_override;
  assign ref_enable_out           = cur.ref_enable_out;
  assign ref_ready_flag           = cur.ref_ready_flag;
  assign ref_buffer_enable        = cur.ref_buffer_enable;
  assign ref_buffer_source_select = cur.ref_buffer_source_select;
  assign converter_enable         = cur.converter_enable;
  assign converter_range_select   = cur.converter_range_select;
  assign converter_source_select  = cur.converter_source_select;
  assign converter_level_code     = cur.converter_level_code;
  assign unbuffered_converter_pin = cur.unbuffered_converter_pin;
  assign buffered_reference_pin   = cur.buffered_reference_pin;
  assign sleep_active             = cur.sleep;

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  AST_REF_ENABLE: assert property (@(posedge pclk) disable iff (!presetn)
    ref_enable_out == (HIGH_VOLTAGE_VARIANT | cur.fixed_reference_control[vref_dac_pkg::REF_ENABLE_BIT]))
    else $error("ref enable wrong");

  AST_HV_ALWAYS_ON: assert property (@(posedge pclk) disable iff (!presetn)
    HIGH_VOLTAGE_VARIANT |-> ref_enable_out)
    else $error("variant reference off");

  AST_UNBUF_ROUTE: assert property (@(posedge pclk) disable iff (!presetn)
    unbuffered_converter_pin |-> converter_level_code == cur.dac_level_select[4:0] && !buffered_reference_pin)
    else $error("bare ladder on pin with buffer");

  AST_PIN_READS_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
    pin_digital_override |-> !ref_pin_digital_in)
    else $error("overridden pin read nonzero");

  AST_CONV_PIN_OVERRIDE: assert property (@(posedge pclk) disable iff (!presetn)
    unbuffered_converter_pin |-> pin_digital_override && !ref_pin_digital_in)
    else $error("converter pin not overridden");

  AST_READ_MASK: assert property (@(posedge pclk) disable iff (!presetn)
    pready && !pslverr |-> prdata[31:8] == 24'h000000)
    else $error("upper read bits set");

  AST_ERR_READS_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
    pready && pslverr |-> prdata == 32'h00000000)
    else $error("unmapped read returned data");

  AST_LEVEL_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && !pready && pwrite && pstrb[0] && paddr == vref_dac_pkg::DAC_LEVEL_SELECT_OFFSET
    |=> converter_level_code == $past(pwdata[4:0]))
    else $error("level code not updated");

  AST_RANGE_FOLLOW: assert property (@(posedge pclk) disable iff (!presetn)
    converter_range_select == cur.dac_control_main[vref_dac_pkg::CONVERTER_RANGE_SELECT_BIT] &&
    converter_source_select == cur.dac_control_main[vref_dac_pkg::CONVERTER_SOURCE_SELECT_BIT])
    else $error("range or source mismatch");

  AST_SLEEP_KEEPS: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(sleep_active) |-> $stable(cur.fixed_reference_control) && $stable(cur.dac_control_main))
    else $error("wake disturbed registers");

  AST_READY_NEEDS_ENABLE: assert property (@(posedge pclk) disable iff (!presetn)
    ref_ready_flag |-> $past(eff_enable, 2))
    else $error("ready without enable");

  AST_BUFFER_PIN: assert property (@(posedge pclk) disable iff (!presetn)
    buffered_reference_pin == ref_buffer_enable)
    else $error("buffer pin mismatch");

endmodule // voltage_ref_dac_control
`default_nettype wire

// ==== bench/voltage_ref_dac_control_test.sv ====
`timescale 1ns/100ps
`default_nettype none
module voltage_ref_dac_control_test;
  typedef struct {
    logic [7:0]  a;
    logic [31:0] d;
    logic [31:0] r;
    logic        e;
  } row_type;

  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0]  pstrb = 4'hF;
  logic        pready, pslverr, ref_pin_in = 1'b1;
  logic [31:0] prdata, rd;
  logic        er, ref_pin_digital_in, pin_digital_override, ref_enable_out, ref_ready_flag;
  logic        ref_buffer_enable, ref_buffer_source_select, converter_enable, converter_range_select;
  logic        converter_source_select, unbuffered_converter_pin, buffered_reference_pin, sleep_active;
  logic [4:0]  converter_level_code;
  logic        hv_enable_out, hv_ready_flag;
  int          err_total = 0;
  int          check_count = 0;
  row_type     rows [7];

  // ----------------------------------------------------------------
  // clock and device
  // ----------------------------------------------------------------
  always #2.5 pclk = ~pclk;

  // short settle count keeps the ready test brief
  voltage_ref_dac_control #(.HIGH_VOLTAGE_VARIANT(1'b0), .SETTLE_COUNT(16'h0008)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .ref_pin_in(ref_pin_in), .ref_pin_digital_in(ref_pin_digital_in),
    .pin_digital_override(pin_digital_override), .ref_enable_out(ref_enable_out),
    .ref_ready_flag(ref_ready_flag), .ref_buffer_enable(ref_buffer_enable),
    .ref_buffer_source_select(ref_buffer_source_select), .converter_enable(converter_enable),
    .converter_range_select(converter_range_select), .converter_source_select(converter_source_select),
    .converter_level_code(converter_level_code), .unbuffered_converter_pin(unbuffered_converter_pin),
    .buffered_reference_pin(buffered_reference_pin), .sleep_active(sleep_active));

  // variant instance: reference on whatever software writes
  voltage_ref_dac_control #(.HIGH_VOLTAGE_VARIANT(1'b1), .SETTLE_COUNT(16'h0008)) dut_hv (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(), .prdata(), .pslverr(), .ref_pin_in(ref_pin_in),
    .ref_pin_digital_in(), .pin_digital_override(), .ref_enable_out(hv_enable_out), .ref_ready_flag(hv_ready_flag),
    .ref_buffer_enable(), .ref_buffer_source_select(), .converter_enable(), .converter_range_select(),
    .converter_source_select(), .converter_level_code(), .unbuffered_converter_pin(), .buffered_reference_pin(),
    .sleep_active());

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic summarize();
    $display("comparisons %0d, mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      err_total++;
      summarize();
    end
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rows[0] = '{8'h04, 32'hFFFF_FFFF, 32'h0000_00E4, 1'b0};
    rows[1] = '{8'h04, 32'h0000_0000, 32'h0000_0000, 1'b0};
    rows[2] = '{8'h08, 32'h0000_00FF, 32'h0000_001F, 1'b0};
    rows[3] = '{8'h08, 32'h0000_000A, 32'h0000_000A, 1'b0};
    rows[4] = '{8'h00, 32'h0000_007F, 32'h0000_0030, 1'b0};
    rows[5] = '{8'h00, 32'h0000_0000, 32'h0000_0000, 1'b0};
    rows[6] = '{8'h10, 32'h0000_00FF, 32'h0000_0000, 1'b1};
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    // reset values of all three registers
    for (int i = 0; i < 3; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0);
      check(rd, 32'h0000_0000);
    end
    // table: write, read back, implemented bits only
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].d);
      check({31'h0, er}, {31'h0, rows[i].e});
      apb(1'b0, rows[i].a, 32'h0);
      check(rd, rows[i].r);
      check({31'h0, er}, {31'h0, rows[i].e});
    end
    // converter controls reach the analog side right after the write
    apb(1'b1, 8'h04, 32'h0000_00E4);
    apb(1'b1, 8'h08, 32'h0000_001F);
    #1;
    check({converter_enable, converter_range_select, converter_source_select}, 3'h7);
    check(converter_level_code, 5'h1F);
    apb(1'b1, 8'h04, 32'h0000_00A0);
    apb(1'b1, 8'h08, 32'h0000_0000);
    #1;
    check({converter_enable, converter_range_select, converter_source_select}, 3'h4);
    check(converter_level_code, 5'h00);
    check({unbuffered_converter_pin, buffered_reference_pin, pin_digital_override}, 3'h5);
    cycles(5);
    check(ref_pin_digital_in, 1'b0);
    // buffer enable takes the pin over, with converter as source
    apb(1'b1, 8'h00, 32'h0000_0030);
    cycles(5);
    check({unbuffered_converter_pin, buffered_reference_pin, pin_digital_override}, 3'h3);
    check({ref_buffer_enable, ref_buffer_source_select, ref_pin_digital_in}, 3'h6);
    // source set without buffer blocks the unbuffered route
    apb(1'b1, 8'h00, 32'h0000_0010);
    cycles(5);
    check({unbuffered_converter_pin, buffered_reference_pin, pin_digital_override}, 3'h0);
    check(ref_pin_digital_in, 1'b1);
    // ready only after the settle count, gone on disable
    apb(1'b1, 8'h00, 32'h0000_0080);
    apb(1'b0, 8'h00, 32'h0);
    check(rd, 32'h0000_0080);
    check({ref_enable_out, ref_ready_flag}, 2'h2);
    cycles(20);
    apb(1'b0, 8'h00, 32'h0);
    check(rd, 32'h0000_00C0);
    check(ref_ready_flag, 1'b1);
    apb(1'b1, 8'h00, 32'h0000_0000);
    cycles(2);
    check({ref_enable_out, ref_ready_flag}, 2'h0);
    check({hv_enable_out, hv_ready_flag}, 2'h3);
    // byte strobe off: write ignored
    @(posedge pclk);
    pstrb <= 4'h0;
    apb(1'b1, 8'h08, 32'h0000_0015);
    pstrb <= 4'hF;
    apb(1'b0, 8'h08, 32'h0);
    check(rd, 32'h0000_0000);
    // sleep and wake leave the controls alone
    apb(1'b1, 8'h00, 32'h0000_0020);
    apb(1'b1, 8'h04, 32'h0000_0044);
    apb(1'b1, 8'h0C, 32'h0000_0001);
    #1;
    check(sleep_active, 1'b1);
    apb(1'b1, 8'h0C, 32'h0000_0000);
    apb(1'b0, 8'h00, 32'h0);
    check(rd, 32'h0000_0020);
    apb(1'b0, 8'h04, 32'h0);
    check(rd, 32'h0000_0044);
    // reset in mid-run clears the controls; variant reference stays on
    apb(1'b1, 8'h08, 32'h0000_0011);
    @(posedge pclk);
    presetn <= 1'b0;
    cycles(2);
    check({ref_buffer_enable, converter_range_select, buffered_reference_pin, converter_level_code}, 8'h00);
    check(hv_enable_out, 1'b1);
    @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0);
      check(rd, 32'h0000_0000);
    end
    summarize();
  end
endmodule // voltage_ref_dac_control_test
`default_nettype wire
